// ==== rtl/tgt_top.sv ====
// Purpose: Row/receive and column/transmit counters with sine stepping.
// Assumes: CPU bus is synchronous to clk; receive carrier is synchronous.
// Notes:   Counters count one step per clk; no clock enable is used.

`timescale 1ns/1ps

// Functional notes
// - Mode field is control bits 2 to 0
// - Control bit 4 picks square or sine
// - 17-bit row counter, two-byte reload register
// - Idle mode: row path inactive, silent
// - Mode change, except to 100, reloads row
// - Interval mode: carry interrupts and reloads
// - Pulse mode: carrier edges capture and interrupt
// - Row tone mode: overflow reloads, no interrupt
// - Row overflow to square divider or sine
// - Column counter runs only with mode bit 2
// - Column write loads counter; overflow reloads
// - Mode 100: column overflow steps sine, silent
// - Mode 101: pulse timing plus column tone
// - Mode 110: like 101 with prescaler
// - Mode 111: row and column tones together
// - Unprescaled modem steps on every overflow
// - Each channel has its own modulo-26 stepper
// - Table maps step to level code
// - Levels hold when steppers stop
module tgt_top
   import tgt_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      sys_rst,
   input  wire tgt_bus_s  cpu_bus,
   output logic [7:0]     cpu_rdata,
   input  wire logic      receive_carrier_in,
   output logic           row_irq,
   output tgt_tone_s      tone_output
);

   ////////////////////////////////////////////////////////////////////////
   // Register state

   logic [15:0] row_reload_register;
   logic [7:0]  column_reload_register;
   logic [7:0]  control;
   logic [16:0] row_counter;
   logic [8:0]  column_counter;
   logic        receive_carrier_prev;
   logic        square_state;
   logic        prescale_state;

   ////////////////////////////////////////////////////////////////////////
   // Decoded bus strobes

   logic wr_row_lo;
   logic wr_row_hi;
   logic wr_column;
   logic wr_control;

   always_comb begin
      wr_row_lo  = cpu_bus.we && (cpu_bus.addr == TGT_ADDR_ROW_LO);
      wr_row_hi  = cpu_bus.we && (cpu_bus.addr == TGT_ADDR_ROW_HI);
      wr_column  = cpu_bus.we && (cpu_bus.addr == TGT_ADDR_COLUMN);
      wr_control = cpu_bus.we && (cpu_bus.addr == TGT_ADDR_CONTROL);
   end

   ////////////////////////////////////////////////////////////////////////
   // Mode decode

   tgt_mode_e mode;
   tgt_mode_e next_mode;
   logic      tone_select;
   logic      mode_change;

   always_comb begin
      mode        = tgt_mode_e'(control[TGT_MODE_MSB:TGT_MODE_LSB]);
      next_mode   = tgt_mode_e'(cpu_bus.wdata[TGT_MODE_MSB:TGT_MODE_LSB]);
      tone_select = control[TGT_TONE_SEL_BIT];
   end

   // A rewrite with the same mode is not a change and keeps counting
   always_comb begin
      mode_change = wr_control && (next_mode != mode)
                    && (next_mode != TGT_MODE_COL_TONE);
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-mode behaviour of the row path

   logic row_active;
   logic row_interval;
   logic row_pulse_width;
   logic row_tone;

   always_comb begin
      row_active      = 1'b0;
      row_interval    = 1'b0;
      row_pulse_width = 1'b0;
      row_tone        = 1'b0;
      case (mode)
         TGT_MODE_IDLE: begin
            row_active = 1'b0;
         end
         TGT_MODE_INTERVAL: begin
            row_active   = 1'b1;
            row_interval = 1'b1;
         end
         TGT_MODE_PULSE: begin
            row_active      = 1'b1;
            row_pulse_width = 1'b1;
         end
         TGT_MODE_ROW_TONE: begin
            row_active = 1'b1;
            row_tone   = 1'b1;
         end
         TGT_MODE_COL_TONE: begin
            row_active = 1'b0;
         end
         TGT_MODE_MODEM: begin
            row_active      = 1'b1;
            row_pulse_width = 1'b1;
         end
         TGT_MODE_MODEM_PS: begin
            row_active      = 1'b1;
            row_pulse_width = 1'b1;
         end
         TGT_MODE_DUAL: begin
            row_active = 1'b1;
            row_tone   = 1'b1;
         end
         default: begin
            row_active = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-mode behaviour of the column path

   logic column_active;
   logic column_prescale;

   always_comb begin
      column_active   = control[TGT_MODE_MSB];
      column_prescale = (mode == TGT_MODE_MODEM_PS);
   end

   ////////////////////////////////////////////////////////////////////////
   // Overflow and edge detection

   logic row_carry;
   logic column_carry;
   logic carrier_edge;
   logic [16:0] row_load_value;
   logic [8:0]  column_load_value;

   // Reload one above the register so a period is value plus two
   always_comb begin
      row_load_value    = {1'b0, row_reload_register} + TGT_ROW_ONE;
      column_load_value = {1'b0, column_reload_register} + TGT_COLUMN_ONE;
      row_carry    = row_active && (row_counter == 17'h00000);
      column_carry = column_active && (column_counter == 9'h000);
      carrier_edge = row_pulse_width
                     && (receive_carrier_in != receive_carrier_prev);
   end

   // Carrier taken as synchronous; one flop gives the previous level
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         receive_carrier_prev <= 1'b0;
      end else begin
         receive_carrier_prev <= receive_carrier_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control register

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         control <= TGT_CONTROL_RESET;
      end else if (wr_control) begin
         control <= cpu_bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Row reload register, two bytes; a capture beats a CPU write

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         row_reload_register <= TGT_ROW_RESET;
      end else if (carrier_edge) begin
         row_reload_register <= row_counter[15:0];
      end else if (wr_row_lo) begin
         row_reload_register[7:0] <= cpu_bus.wdata;
      end else if (wr_row_hi) begin
         row_reload_register[15:8] <= cpu_bus.wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Row counter

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         row_counter <= {1'b0, TGT_ROW_RESET};
      end else if (mode_change) begin
         row_counter <= row_load_value;
      end else if (!row_active) begin
         row_counter <= row_counter;
      end else if (row_carry) begin
         row_counter <= row_load_value;
      end else begin
         row_counter <= row_counter - TGT_ROW_ONE;
      end
   end

   // Interrupt pulse: interval carries and carrier edges only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         row_irq <= 1'b0;
      end else begin
         row_irq <= (row_interval && row_carry)
                    || carrier_edge;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Column reload register and counter

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         column_reload_register <= TGT_COLUMN_RESET;
      end else if (wr_column) begin
         column_reload_register <= cpu_bus.wdata;
      end
   end

   // A CPU write lands in the counter at once, not at the next overflow
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         column_counter <= {1'b0, TGT_COLUMN_RESET};
      end else if (wr_column) begin
         column_counter <= {1'b0, cpu_bus.wdata} + TGT_COLUMN_ONE;
      end else if (!column_active) begin
         column_counter <= column_counter;
      end else if (column_carry) begin
         column_counter <= column_load_value;
      end else begin
         column_counter <= column_counter - TGT_COLUMN_ONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit prescaler and square wave divider

   // Prescaler halves the column step rate in the prescaled modem mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prescale_state <= 1'b0;
      end else if (!column_prescale) begin
         prescale_state <= 1'b0;
      end else if (column_carry) begin
         prescale_state <= !prescale_state;
      end
   end

   // Square output toggles on row overflow in the row tone modes when tone select is set
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         square_state <= 1'b0;
      end else if (row_tone && tone_select && row_carry) begin
         square_state <= !square_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Step pulses for the two sine channels

   logic [TGT_CHANNELS-1:0] step_pulse;

   always_comb begin
      step_pulse[TGT_CH_ROW] = row_tone && !tone_select
                               && row_carry;
      if (column_prescale) begin
         step_pulse[TGT_CH_COLUMN] = column_carry && prescale_state;
      end else begin
         step_pulse[TGT_CH_COLUMN] = column_carry;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Identical step counters, one per channel

   logic [TGT_LEVEL_W-1:0] level [TGT_CHANNELS];

   genvar ch;
   generate
      for (ch = 0; ch < TGT_CHANNELS; ch++) begin : g_sine
         tgt_sine_step u_step (
            .clk        (clk),
            .sys_rst    (sys_rst),
            .step_pulse (step_pulse[ch]),
            .step       (),
            .level      (level[ch])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Tone outputs, registered

   // Sine enables tell the analog side which converter to sum
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tone_output              <= '0;
         tone_output.row_level    <= TGT_LEVEL_MID;
         tone_output.column_level <= TGT_LEVEL_MID;
      end else begin
         tone_output.row_level      <= level[TGT_CH_ROW];
         tone_output.column_level   <= level[TGT_CH_COLUMN];
         tone_output.square_out     <= square_state;
         tone_output.row_sine_on    <= row_tone && !tone_select;
         tone_output.column_sine_on <= column_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path; one cycle latency, unmapped reads give zero

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cpu_rdata <= TGT_RDATA_IDLE;
      end else if (cpu_bus.re) begin
         case (cpu_bus.addr)
            TGT_ADDR_ROW_LO: begin
               cpu_rdata <= row_reload_register[7:0];
            end
            TGT_ADDR_ROW_HI: begin
               cpu_rdata <= row_reload_register[15:8];
            end
            TGT_ADDR_COLUMN: begin
               cpu_rdata <= column_reload_register;
            end
            TGT_ADDR_CONTROL: begin
               cpu_rdata <= control;
            end
            default: begin
               cpu_rdata <= TGT_RDATA_IDLE;
            end
         endcase
      end else begin
         cpu_rdata <= TGT_RDATA_IDLE;
      end
   end

endmodule

// ==== rtl/tgt_pkg.sv ====
// Purpose: Shared constants and types for the tone generator timer.
// Assumes: 8-bit internal CPU bus, byte addresses in page zero.
// Notes:   Every offset, field position and reset value lives here.

package tgt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte addresses
   localparam logic [15:0] TGT_ADDR_ROW_LO  = 16'h00f4;
   localparam logic [15:0] TGT_ADDR_ROW_HI  = 16'h00f5;
   localparam logic [15:0] TGT_ADDR_COLUMN  = 16'h00f6;
   localparam logic [15:0] TGT_ADDR_CONTROL = 16'h00f7;

   ////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int TGT_MODE_LSB     = 0;
   localparam int TGT_MODE_MSB     = 2;
   localparam int TGT_TONE_SEL_BIT = 4;

   // Reset values
   localparam logic [15:0] TGT_ROW_RESET     = 16'h0000;
   localparam logic [7:0]  TGT_COLUMN_RESET  = 8'h00;
   localparam logic [7:0]  TGT_CONTROL_RESET = 8'h00;
   localparam logic [7:0]  TGT_RDATA_IDLE    = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Sine step generator
   localparam int          TGT_STEP_W    = 5;
   localparam int          TGT_LEVEL_W   = 4;
   localparam logic [4:0]  TGT_STEP_LAST = 5'h19;  // 26 steps, 0 to 25
   localparam logic [4:0]  TGT_STEP_ZERO = 5'h00;
   localparam logic [3:0]  TGT_LEVEL_MID = 4'h8;
   localparam int          TGT_CHANNELS  = 2;
   localparam int          TGT_CH_ROW    = 0;
   localparam int          TGT_CH_COLUMN = 1;

   // Counters reload with value plus one, giving value plus two per period
   localparam logic [16:0] TGT_ROW_ONE    = 17'h00001;
   localparam logic [8:0]  TGT_COLUMN_ONE = 9'h001;

   // Step number to level code
   localparam logic [3:0] TGT_SINE_TABLE [26] = '{
      4'h8, 4'ha, 4'hb, 4'hd, 4'he, 4'hf, 4'hf, 4'hf, 4'hf, 4'he,
      4'hd, 4'hb, 4'ha, 4'h8, 4'h6, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0,
      4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h4};

   typedef enum logic [2:0] {
      TGT_MODE_IDLE     = 3'b000,
      TGT_MODE_INTERVAL = 3'b001,
      TGT_MODE_PULSE    = 3'b010,
      TGT_MODE_ROW_TONE = 3'b011,
      TGT_MODE_COL_TONE = 3'b100,
      TGT_MODE_MODEM    = 3'b101,
      TGT_MODE_MODEM_PS = 3'b110,
      TGT_MODE_DUAL     = 3'b111
   } tgt_mode_e;

   // CPU bus request
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } tgt_bus_s;

   // Converter-facing outputs
   typedef struct packed {
      logic [3:0] row_level;
      logic [3:0] column_level;
      logic       square_out;
      logic       row_sine_on;
      logic       column_sine_on;
   } tgt_tone_s;

endpackage

// ==== rtl/tgt_sine_step.sv ====
// Purpose: One sine channel: modulo-26 step counter and level table.
// Assumes: step_pulse is a one-cycle pulse from the channel divider.
// Notes:   Level holds whenever no pulse arrives, so stopping is smooth.

`timescale 1ns/1ps

module tgt_sine_step
   import tgt_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              step_pulse,
   output logic [TGT_STEP_W-1:0]  step,
   output logic [TGT_LEVEL_W-1:0] level
);

   logic [TGT_STEP_W-1:0] next_step;

   ////////////////////////////////////////////////////////////////////////
   // Wrap after the last of 26 steps
   always_comb begin
      if (step == TGT_STEP_LAST) begin
         next_step = TGT_STEP_ZERO;
      end else begin
         next_step = step + TGT_STEP_W'(1);
      end
   end

   // Step advances only on a divider overflow
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         step <= TGT_STEP_ZERO;
      end else if (step_pulse) begin
         step <= next_step;
      end
   end

   // Level is registered from the table; holds when counting stops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         level <= TGT_LEVEL_MID;
      end else if (step_pulse) begin
         level <= TGT_SINE_TABLE[next_step];
      end
   end

endmodule

// ==== verif/tgt_top_monitor.sv ====
// Purpose: Port checker for the tone generator timer.
// Assumes: Only top ports are visible; CPU writes are shadowed here.
// Notes:   Hold checks allow a few cycles of output pipeline.
`timescale 1ns/1ps
module tgt_top_monitor
   import tgt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire tgt_bus_s   cpu_bus,
   input  wire logic [7:0] cpu_rdata,
   input  wire logic       receive_carrier_in,
   input  wire logic       row_irq,
   input  wire tgt_tone_s  tone_output
);
   logic [7:0] ctrl;
   logic [7:0] col_sh;
   logic       car_q;
   logic [2:0] row_off;
   logic [2:0] col_off;
   logic       pulse;
   logic       quiet;
   logic       sq_on;
   logic       row_on;

   // Decoded view of the shadowed control byte
   assign pulse  = ctrl[2:0] inside {3'b010, 3'b101, 3'b110};
   assign quiet  = ctrl[2:0] inside {3'b000, 3'b011, 3'b100, 3'b111};
   assign sq_on  = (ctrl[1:0] == 2'b11) && ctrl[4];
   assign row_on = (ctrl[1:0] == 2'b11) && !ctrl[4];

   ////////////////////////////////////////////////////////////////////////
   // Control shadow, cleared like the design
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= 8'h00;
      end else if (cpu_bus.we && cpu_bus.addr == TGT_ADDR_CONTROL) begin
         ctrl <= cpu_bus.wdata;
      end
   end

   // Column reload shadow
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         col_sh <= 8'h00;
      end else if (cpu_bus.we && cpu_bus.addr == TGT_ADDR_COLUMN) begin
         col_sh <= cpu_bus.wdata;
      end
   end

   // Previous carrier sample, taken even in reset like a synchroniser
   always_ff @(posedge clk) begin
      car_q <= receive_carrier_in;
   end

   // Cycles since each sine channel was last enabled, saturating
   always_ff @(posedge clk) begin
      if (sys_rst || row_on) begin
         row_off <= 3'h0;
      end else if (row_off != 3'h7) begin
         row_off <= row_off + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || ctrl[2]) begin
         col_off <= 3'h0;
      end else if (col_off != 3'h7) begin
         col_off <= col_off + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   rdata_idle_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      !$past(cpu_bus.re) || !($past(cpu_bus.addr) inside {[16'h00f4:16'h00f7]})
      |-> cpu_rdata == 8'h00) else $error("read data not idle");
   ctrl_read_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      $past(cpu_bus.re) && $past(cpu_bus.addr) == TGT_ADDR_CONTROL
      |-> cpu_rdata == $past(ctrl)) else $error("control read wrong");
   col_read_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      $past(cpu_bus.re) && $past(cpu_bus.addr) == TGT_ADDR_COLUMN
      |-> cpu_rdata == $past(col_sh)) else $error("column read wrong");
   quiet_modes_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      quiet && $past(quiet) |-> !row_irq) else $error("irq in quiet mode");
   square_hold_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      !$past(sq_on) && !$past(sq_on, 2) |-> $stable(tone_output.square_out))
      else $error("square moved while off");
   row_hold_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      row_off >= 3'h5 |-> $stable(tone_output.row_level))
      else $error("row level moved while stopped");
   col_hold_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      col_off >= 3'h5 |-> $stable(tone_output.column_level))
      else $error("column level moved while stopped");
   pulse_irq_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      pulse && (receive_carrier_in != car_q) |=> row_irq)
      else $error("carrier edge gave no irq");
   sine_enable_a:
   assert property (@(posedge clk) disable iff (sys_rst)
      tone_output.row_sine_on == $past(row_on)
      && tone_output.column_sine_on == $past(ctrl[2]))
      else $error("sine enable wrong");
endmodule

bind tgt_top tgt_top_monitor u_tgt_top_monitor (
   .clk(clk), .sys_rst(sys_rst), .cpu_bus(cpu_bus), .cpu_rdata(cpu_rdata),
   .receive_carrier_in(receive_carrier_in), .row_irq(row_irq),
   .tone_output(tone_output));

// ==== verif/tgt_cpu_model.sv ====
// Purpose: Embedded CPU side of the internal register bus.
// Assumes: One strobe cycle per access, driven on falling edges.
// Notes:   Released lines show inverted values, never stale ones.
`timescale 1ns/1ps
module tgt_cpu_model
   import tgt_pkg::*;
(
   input  wire logic       clk,
   input  wire logic [7:0] cpu_rdata,
   output tgt_bus_s        cpu_bus
);
   initial cpu_bus = '0;

   // Software reload choice: oscillator over K times frequency, less two
   function automatic int reload_for(input int osc, input int k, input int f);
      return osc / (k * f) - 2;
   endfunction

   // Single-cycle write strobe
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk);
      cpu_bus.addr  = a;
      cpu_bus.wdata = d;
      cpu_bus.we    = 1'b1;
      @(posedge clk);
      @(negedge clk);
      cpu_bus.we    = 1'b0;
      cpu_bus.addr  = ~a;
      cpu_bus.wdata = ~d;
   endtask

   // Read data is registered, so it is valid at the next falling edge
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk);
      cpu_bus.addr = a;
      cpu_bus.re   = 1'b1;
      @(posedge clk);
      @(negedge clk);
      cpu_bus.re   = 1'b0;
      cpu_bus.addr = ~a;
      d = cpu_rdata;
   endtask
endmodule

// ==== verif/test_tone_generator_timer.sv ====
// Purpose: Self-checking bench for the tone generator timer.
// Assumes: CPU model drives the bus; carrier changes on falling edges.
// Notes:   Step model follows each sine channel from reset.
`timescale 1ns/1ps
module test_tone_generator_timer
   import tgt_pkg::*;
;
   logic        clk;
   logic        sys_rst;
   tgt_bus_s    cpu_bus;
   logic [7:0]  cpu_rdata;
   logic        receive_carrier_in;
   logic        row_irq;
   tgt_tone_s   tone_output;
   int          error_cnt;
   int          checks_done;
   int          cyc;
   int          t0;
   int          k;
   int          c;
   int          step_m [2];
   int unsigned seed;
   logic [7:0]  rd_v;
   logic [15:0] r_val;
   logic [15:0] e16;

   tgt_top u_tgt_top (.clk(clk), .sys_rst(sys_rst), .cpu_bus(cpu_bus),
      .cpu_rdata(cpu_rdata), .receive_carrier_in(receive_carrier_in),
      .row_irq(row_irq), .tone_output(tone_output));
   tgt_cpu_model u_tgt_cpu_model (.clk(clk), .cpu_rdata(cpu_rdata),
      .cpu_bus(cpu_bus));

   // 125 MHz clock and edge count
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("Checks made %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk_val(input string n, input logic [15:0] e,
                          input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_cyc(input string n, input int e, input int g);
      checks_done++;
      if (g != e) begin
         error_cnt++;
         $display("Error %s expected %0d seen %0d", n, e, g);
      end
   endtask

   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   function automatic logic [3:0] lvl(input int ch);
      return ch ? tone_output.column_level : tone_output.row_level;
   endfunction

   task automatic set_mode(input logic sel, input tgt_mode_e m);
      u_tgt_cpu_model.wr(TGT_ADDR_CONTROL, {3'b000, sel, 1'b0, m});
      t0 = cyc;
   endtask

   task automatic set_row(input logic [15:0] v);
      u_tgt_cpu_model.wr(TGT_ADDR_ROW_LO, v[7:0]);
      u_tgt_cpu_model.wr(TGT_ADDR_ROW_HI, v[15:8]);
   endtask

   // Bounded wait for an irq pulse or a square edge
   task automatic wait_out(input logic sq, output int n);
      logic s;
      s = tone_output.square_out;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while ((sq ? tone_output.square_out === s : row_irq !== 1'b1)
                 && n < 3000);
   endtask

   // Level changes must walk the table; repeated codes stretch the gap
   task automatic watch_steps(input int ch, input int per, input int n);
      logic [3:0] last;
      int s;
      int d;
      int g;
      for (int i = 0; i < n; i++) begin
         last = lvl(ch);
         g = 0;
         do begin
            @(posedge clk);
            #1;
            g++;
         end while (lvl(ch) === last && g < 4000);
         d = 0;
         s = step_m[ch];
         do begin
            s = (s + 1) % 26;
            d++;
         end while (TGT_SINE_TABLE[s] == TGT_SINE_TABLE[step_m[ch]]);
         step_m[ch] = s;
         chk_val("level", 16'(TGT_SINE_TABLE[s]), 16'(lvl(ch)));
         if (i > 0) chk_cyc("step gap", d * per, g);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog sized well past the expected run of under two thousand cycles
   initial begin
      #400000;
      error_cnt++;
      $display("Error watchdog expired");
      end_sim();
   end

   initial begin
      seed = 32'd77108;
      sys_rst = 1'b1;
      receive_carrier_in = 1'b0;
      cyc = 0;
      step_m = '{0, 0};
      repeat (10) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      chk_val("reset lvl", 16'({2{TGT_LEVEL_MID}}),
              16'({lvl(0), lvl(1)}));
      // Reset values, then write and read back, unmapped places included
      for (int a = 4; a < 9; a++) begin
         u_tgt_cpu_model.rd(16'h00f0 + a[15:0], rd_v);
         chk_val("reset value", 16'h0000, 16'(rd_v));
      end
      for (int a = 3; a < 9; a++) begin
         r_val[7:0] = (a == 7) ? (rnd() & 8'hf8) : rnd();
         u_tgt_cpu_model.wr(16'h00f0 + a[15:0], r_val[7:0]);
         u_tgt_cpu_model.rd(16'h00f0 + a[15:0], rd_v);
         e16 = (a >= 4 && a <= 7) ? {8'h00, r_val[7:0]} : 16'h0000;
         chk_val("read back", e16, {8'h00, rd_v});
      end
      // Interval timer: first carry counts from the mode change
      r_val = {8'h00, rnd() & 8'h1f} + 16'h0003;
      set_row(r_val);
      set_mode(1'b0, TGT_MODE_INTERVAL);
      wait_out(1'b0, k);
      chk_cyc("first interval", r_val + 2, k);
      wait_out(1'b0, k);
      chk_cyc("interval", r_val + 2, k);
      set_mode(1'b0, TGT_MODE_IDLE);
      repeat (40) @(posedge clk);
      // Pulse width: large reload so the count never wraps here
      r_val = {8'h40 | rnd(), rnd()};
      set_row(r_val);
      set_mode(1'b0, TGT_MODE_PULSE);
      repeat (2) begin
         repeat (5 + rnd() % 20) @(negedge clk);
         receive_carrier_in = ~receive_carrier_in;
         k = cyc + 1 - t0;
         e16 = r_val + 16'h0002 - k[15:0];
         @(posedge clk);
         #1;
         chk_val("capture irq", 16'h0001, {15'h0000, row_irq});
         u_tgt_cpu_model.rd(TGT_ADDR_ROW_LO, rd_v);
         chk_val("capture lo", 16'(e16[7:0]), 16'(rd_v));
         u_tgt_cpu_model.rd(TGT_ADDR_ROW_HI, rd_v);
         chk_val("capture hi", 16'(e16[15:8]), 16'(rd_v));
      end
      // Square wave toggles once per row period
      r_val = 16'(u_tgt_cpu_model.reload_for(1000, 4, 25));
      set_row(r_val);
      set_mode(1'b1, TGT_MODE_ROW_TONE);
      wait_out(1'b1, k);
      wait_out(1'b1, k);
      chk_cyc("square half period", r_val + 2, k);
      // Row sine through a full wrap, stopped between pulses
      set_mode(1'b0, TGT_MODE_ROW_TONE);
      watch_steps(0, r_val + 2, 30);
      set_mode(1'b0, TGT_MODE_IDLE);
      repeat (30) @(posedge clk);
      // Column tone, then prescaled and plain modem, then dual tone
      c = u_tgt_cpu_model.reload_for(1000, 26, 4);
      set_mode(1'b0, TGT_MODE_COL_TONE);
      u_tgt_cpu_model.wr(TGT_ADDR_COLUMN, c[7:0]);
      watch_steps(1, c + 2, 24);
      set_mode(1'b0, TGT_MODE_MODEM_PS);
      watch_steps(1, 2 * (c + 2), 6);
      set_mode(1'b0, TGT_MODE_MODEM);
      fork
         watch_steps(1, c + 2, 6);
         begin
            repeat (20) @(negedge clk);
            receive_carrier_in = ~receive_carrier_in;
            @(posedge clk);
            #1;
            chk_val("modem irq", 16'h0001, {15'h0000, row_irq});
         end
      join
      // The modem capture replaced the row value; restore it for the tones
      set_row(r_val);
      set_mode(1'b0, TGT_MODE_DUAL);
      fork
         watch_steps(0, r_val + 2, 8);
         watch_steps(1, c + 2, 8);
      join
      set_mode(1'b0, TGT_MODE_IDLE);
      repeat (40) @(posedge clk);
      end_sim();
   end
endmodule
